// >>> logic/pmp_pkg.sv
// Package: address map, field layouts and carriers for program memory protection
package pmp_pkg;
    localparam int ADDR_W = 21;
    localparam int DATA_W = 16;
    localparam int NUM_BLK = 5;
    // Block map: boot, blocks 0..3
    localparam logic [20:0] BOOT_START = 21'h000000;
    localparam logic [20:0] BOOT_END = 21'h0007FF;
    localparam logic [20:0] BLK0_START = 21'h000800;
    localparam logic [20:0] BLK0_END = 21'h003FFF;
    localparam logic [20:0] BLK1_START = 21'h004000;
    localparam logic [20:0] BLK2_START = 21'h008000;
    localparam logic [20:0] BLK3_START = 21'h00C000;
    localparam logic [20:0] PROG_TOP = 21'h00FFFF;
    // Special locations outside user memory
    localparam logic [20:0] CFG_BASE = 21'h300000;
    localparam logic [20:0] CFG_LAST = 21'h30000F;
    localparam logic [20:0] DEVID_ADDR = 21'h3FFFFE;
    // Protection word layout in the protection config word
    localparam int WRT_POS = 0;
    localparam int EBTR_POS = 5;
    localparam int CP_POS = 10;
    localparam logic [DATA_W-1:0] PROT_RESET = 16'h7FFF;
    localparam logic [20:0] PROT_ADDR = 21'h300008;
    localparam logic [2:0] BLK_NONE = 3'h7;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_READ,
        OP_WRITE
    } pmp_op_type;

    typedef struct packed {
        pmp_op_type        op;
        logic [ADDR_W-1:0] table_pointer;
        logic [ADDR_W-1:0] pc;
        logic [DATA_W-1:0] wdata;
        logic              external;
    } pmp_req_type;
endpackage

// >>> logic/pmp_block_decode.sv
// Block index decode for one program memory address
`timescale 1ns/1ps
`default_nettype none
module pmp_block_decode
    import pmp_pkg::*;
(
    input  wire logic [ADDR_W-1:0] addr,
    output logic [2:0]             blk
);
    // Boot is index 4 so blocks 0..3 keep their natural numbers
    always_comb begin
        if (addr <= BOOT_END) begin                          // see R12
            blk = 3'h4;
        end else if (addr <= BLK0_END) begin                 // see R12
            blk = 3'h0;
        end else if (addr < BLK2_START) begin                // see R13
            blk = 3'h1;
        end else if (addr < BLK3_START) begin                // see R13
            blk = 3'h2;
        end else if (addr <= PROG_TOP) begin                 // see R13
            blk = 3'h3;
        end else begin
            blk = BLK_NONE;
        end
    end
endmodule
`default_nettype wire

// >>> logic/pmp_guard.sv
// Program flash access guard: table reads, table writes, erase, config
`timescale 1ns/1ps
`default_nettype none
// Contract
// R1 - Table ops reach all user memory
// R2 - Table read at ID returns identification word
// R3 - Config words readable and writable by table ops
// R4 - Code-protect ignored for internal accesses
// R5 - External access to code-protected block refused
// R6 - Write-protect zero blocks every table write; external writes here are checked against code protect only
// R7 - Same-block table read returns true data
// R8 - Other-block table read returns zeros
// R9 - Protection bits go only from one to zero
// R10 - Only erase returns protection bits to one
// R11 - Erase started only by external programmer
// R12 - Boot 000000-0007FF, block 0 000800-003FFF
// R13 - Blocks 1..3 at 004000, 008000, 00C000
// R14 - Read protection compares PC block, pointer block
// R15 - Suppressed write leaves memory untouched
module pmp_guard
    import pmp_pkg::*;
#(
    parameter logic [DATA_W-1:0] DEVICE_ID = 16'h1234  // Arbitrary identification value
)(
    input  wire logic              REF_CLK,
    input  wire logic              RST_N,
    input  wire pmp_req_type       REQ,
    input  wire logic              ERASE_CHIP,
    input  wire logic              ERASE_BLOCK,
    input  wire logic [2:0]        ERASE_SEL,
    input  wire logic              ERASE_EXTERNAL,
    input  wire logic [DATA_W-1:0] FLASH_RDATA,
    output logic [DATA_W-1:0]      RDATA,
    output logic                   RVALID,
    output logic                   REFUSED,
    output logic                   FLASH_WE,
    output logic [ADDR_W-1:0]      FLASH_ADDR,
    output logic [DATA_W-1:0]      FLASH_WDATA,
    output logic                   FLASH_ERASE,
    output logic [2:0]             FLASH_ERASE_SEL,
    output logic [DATA_W-1:0]      PROT_WORD
);
    import pmp_pkg::*;

    // Fixed words (ID, protection word, refusals) answer one cycle after the op and
    // flash words two, so a fixed read right behind a flash read would collide
    // All module state in one packed struct
    typedef struct packed {
        logic [DATA_W-1:0] prot;
        logic [DATA_W-1:0] rdata;
        logic              rvalid;
        logic              refused;
        logic              we;
        logic [ADDR_W-1:0] waddr;
        logic [DATA_W-1:0] wdata;
        logic              erase;
        logic [2:0]        erase_sel;
        logic              rd_pend;
        logic              rd_zero;
    } pmp_state_type;

    pmp_state_type state;
    pmp_state_type next_state;
    logic [2:0]    ptr_blk;
    logic [2:0]    pc_blk;
    logic          in_user;
    logic          is_cfg;
    logic          is_id;
    logic          wrt_ok;
    logic          ebtr_ok;
    logic          cp_ok;

    // Block of the target and of the executing instruction
    pmp_block_decode u_ptr_dec (
        .addr (REQ.table_pointer),                 // see R12 R13
        .blk  (ptr_blk)
    );
    pmp_block_decode u_pc_dec (
        .addr (REQ.pc),                            // see R12 R13 R14
        .blk  (pc_blk)
    );

    // Per-block protection lookup
    // Addresses outside user memory carry no protection bits
    always_comb begin
        in_user = (ptr_blk != BLK_NONE);
        is_cfg  = (REQ.table_pointer >= CFG_BASE) && (REQ.table_pointer <= CFG_LAST);
        is_id   = (REQ.table_pointer == DEVID_ADDR);
        wrt_ok  = 1'b1;
        ebtr_ok = 1'b1;
        cp_ok   = 1'b1;
        if (in_user) begin
            wrt_ok  = state.prot[WRT_POS + 32'(ptr_blk)];
            ebtr_ok = state.prot[EBTR_POS + 32'(ptr_blk)];
            cp_ok   = state.prot[CP_POS + 32'(ptr_blk)];
        end
    end

    // Request handling; erase owns the cycle it arrives in
    always_comb begin
        next_state         = state;
        next_state.we      = 1'b0;
        next_state.erase   = 1'b0;
        next_state.rvalid  = state.rd_pend;
        next_state.rdata   = state.rd_zero ? '0 : FLASH_RDATA;  // see R8
        next_state.rd_pend = 1'b0;
        next_state.rd_zero = 1'b0;
        next_state.refused = 1'b0;
        if (ERASE_EXTERNAL && (ERASE_CHIP || ERASE_BLOCK)) begin  // see R11
            // Any table op in this cycle is dropped
            next_state.erase = 1'b1;
            if (ERASE_CHIP) begin
                next_state.prot      = PROT_RESET;                 // see R10
                next_state.erase_sel = BLK_NONE;
            end else begin
                next_state.erase_sel = ERASE_SEL;
                if (ERASE_SEL <= 3'h4) begin
                    next_state.prot[WRT_POS + 32'(ERASE_SEL)]  = 1'b1;  // see R10
                    next_state.prot[EBTR_POS + 32'(ERASE_SEL)] = 1'b1;
                    next_state.prot[CP_POS + 32'(ERASE_SEL)]   = 1'b1;
                end
            end
        end else if (REQ.op == OP_READ) begin
            if (is_id) begin
                next_state.rvalid = 1'b1;                          // see R2
                next_state.rdata  = DEVICE_ID;
            end else if (REQ.table_pointer == PROT_ADDR) begin
                next_state.rvalid = 1'b1;                          // see R3
                next_state.rdata  = state.prot;
            end else if (REQ.external && !cp_ok) begin
                next_state.refused = 1'b1;                         // see R5
                next_state.rvalid  = 1'b1;
                next_state.rdata   = '0;
            end else begin
                // Internal reads ignore code protect; EBTR checks PC block
                next_state.rd_pend = 1'b1;                         // see R1 R4
                next_state.rd_zero = !REQ.external && !ebtr_ok
                                     && (pc_blk != ptr_blk);       // see R7 R14
            end
        end else if (REQ.op == OP_WRITE) begin
            // The protection word can only lose bits here
            if (REQ.table_pointer == PROT_ADDR) begin
                next_state.prot = state.prot & REQ.wdata;          // see R9 R3
            end else if (REQ.external ? !cp_ok : (in_user && !wrt_ok)) begin
                next_state.refused = 1'b1;                         // see R5 R6 R15
            end else begin
                next_state.we    = 1'b1;                           // see R1 R3
                next_state.waddr = REQ.table_pointer;
                next_state.wdata = REQ.wdata;
            end
        end
    end

    // Protection bits are erased state after reset
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state <= '{prot: PROT_RESET, default: '0};
        end else begin
            state <= next_state;
        end
    end

    // Outputs straight from state
    always_comb begin
        RDATA           = state.rdata;
        RVALID          = state.rvalid;
        REFUSED         = state.refused;
        FLASH_WE        = state.we;
        FLASH_WDATA     = state.wdata;
        FLASH_ERASE     = state.erase;
        FLASH_ERASE_SEL = state.erase_sel;
        PROT_WORD       = state.prot;
        FLASH_ADDR      = state.waddr;  // Write address only; reads use the pointer
    end

    // Table read that goes to the flash array
    sequence s_read_req;
        REQ.op == OP_READ && !is_id && REQ.table_pointer != PROT_ADDR
            && !(ERASE_EXTERNAL && (ERASE_CHIP || ERASE_BLOCK));
    endsequence

    a_wrt_block_refuse: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R6
        REQ.op == OP_WRITE && !REQ.external && in_user && !wrt_ok
            && !ERASE_CHIP && !ERASE_BLOCK |=> !FLASH_WE && REFUSED)
        else $error("write reached a write-protected block");
    a_prot_one_way: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R9
        !$past(ERASE_EXTERNAL) |-> (PROT_WORD & ~$past(PROT_WORD)) == '0)
        else $error("protection bit rose without erase");
    a_chip_erase: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R10
        ERASE_EXTERNAL && ERASE_CHIP |=> PROT_WORD == PROT_RESET && FLASH_ERASE)
        else $error("chip erase did not restore protection");
    a_no_int_erase: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R11
        !ERASE_EXTERNAL |=> !FLASH_ERASE)
        else $error("erase started without external programmer");
    a_cross_read_zero: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R8
        s_read_req and (!REQ.external && !ebtr_ok && pc_blk != ptr_blk && in_user)
            |-> ##2 RVALID && RDATA == '0)
        else $error("cross-block read returned data");
    a_same_read_true: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R7
        s_read_req and (!REQ.external && pc_blk == ptr_blk && in_user)
            |-> ##2 RVALID && RDATA == $past(FLASH_RDATA))
        else $error("same-block read not true data");
    a_id_read: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R2
        REQ.op == OP_READ && is_id && !ERASE_EXTERNAL |=> RVALID && RDATA == DEVICE_ID)
        else $error("identification read wrong");
    a_ext_cp_refuse: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R5
        REQ.op != OP_NONE && REQ.external && in_user && !cp_ok && !ERASE_EXTERNAL
            |=> REFUSED && !FLASH_WE)
        else $error("external access to code-protected block");
    a_user_write_ok: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R1
        REQ.op == OP_WRITE && !REQ.external && in_user && wrt_ok && !ERASE_EXTERNAL
            |=> FLASH_WE && FLASH_ADDR == $past(REQ.table_pointer))
        else $error("permitted write not issued");

    // Erase strobes as the guard sees them
    sequence s_erase_req;
        ERASE_EXTERNAL && (ERASE_CHIP || ERASE_BLOCK);
    endsequence
    sequence s_blk_erase;
        ERASE_EXTERNAL && ERASE_BLOCK && !ERASE_CHIP;
    endsequence

    // An erase owns its cycle; a table op beside it must leave no trace
    a_erase_drops_op: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R11
        s_erase_req |=> !FLASH_WE && !REFUSED)
        else $error("table op acted beside an erase");
    a_block_erase: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R10
        s_blk_erase |=> FLASH_ERASE && FLASH_ERASE_SEL == $past(ERASE_SEL)
            && ($past(PROT_WORD) & ~PROT_WORD) == '0)
        else $error("block erase pulse or protection wrong");
    a_chip_erase_sel: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R10
        ERASE_EXTERNAL && ERASE_CHIP |=> FLASH_ERASE_SEL == BLK_NONE)
        else $error("chip erase not flagged as whole chip");

    // Protection word and config space through table ops
    a_prot_read: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R3
        REQ.op == OP_READ && REQ.table_pointer == PROT_ADDR && !ERASE_EXTERNAL
            |=> RVALID && RDATA == $past(PROT_WORD))
        else $error("protection word read wrong");
    a_prot_and_write: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R9
        REQ.op == OP_WRITE && REQ.table_pointer == PROT_ADDR && !ERASE_EXTERNAL
            |=> PROT_WORD == ($past(PROT_WORD) & $past(REQ.wdata)))
        else $error("protection word write set a bit");
    a_cfg_write: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R3
        REQ.op == OP_WRITE && is_cfg && REQ.table_pointer != PROT_ADDR && !ERASE_EXTERNAL
            |=> FLASH_WE && FLASH_ADDR == $past(REQ.table_pointer))
        else $error("config word write not issued");

    // Code protect only matters to the external programmer
    a_int_ignore_cp: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R4
        REQ.op != OP_NONE && !REQ.external && in_user && !cp_ok && wrt_ok
            && !ERASE_EXTERNAL |=> !REFUSED)
        else $error("internal access refused by code protect");
    a_ext_cp_zero: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R5
        REQ.op == OP_READ && REQ.external && in_user && !cp_ok && !ERASE_EXTERNAL
            |=> RVALID && RDATA == '0)
        else $error("external read of protected block leaked data");

    // Refused and permitted writes, address and data side
    a_wrt_keep_port: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R15
        REQ.op == OP_WRITE && !REQ.external && in_user && !wrt_ok
            && !ERASE_EXTERNAL |=> $stable(FLASH_ADDR) && $stable(FLASH_WDATA))
        else $error("refused write disturbed the flash port");
    a_user_write_data: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R1
        REQ.op == OP_WRITE && !REQ.external && in_user && wrt_ok && !ERASE_EXTERNAL
            |=> FLASH_WDATA == $past(REQ.wdata))
        else $error("permitted write carried wrong data");

    // Address map as both decoders must see it
    a_boot_map: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R12
        REQ.table_pointer <= BOOT_END |-> ptr_blk == 3'h4)
        else $error("boot block decode wrong");
    a_blk0_map: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R12
        REQ.table_pointer >= BLK0_START && REQ.table_pointer <= BLK0_END |-> ptr_blk == 3'h0)
        else $error("block 0 decode wrong");
    a_blk1_map: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R13
        REQ.table_pointer >= BLK1_START && REQ.table_pointer < BLK2_START |-> ptr_blk == 3'h1)
        else $error("block 1 decode wrong");
    a_blk2_map: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R13
        REQ.table_pointer >= BLK2_START && REQ.table_pointer < BLK3_START |-> ptr_blk == 3'h2)
        else $error("block 2 decode wrong");
    a_blk3_map: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R13
        REQ.table_pointer >= BLK3_START && REQ.table_pointer <= PROG_TOP |-> ptr_blk == 3'h3)
        else $error("block 3 decode wrong");
    a_off_map: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R13
        REQ.table_pointer > PROG_TOP |-> ptr_blk == BLK_NONE)
        else $error("address above user memory decoded as a block");
    a_pc_boot_map: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R14
        REQ.pc <= BOOT_END |-> pc_blk == 3'h4)
        else $error("program counter boot decode wrong");
    a_pc_blk0_map: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R14
        REQ.pc >= BLK0_START && REQ.pc <= BLK0_END |-> pc_blk == 3'h0)
        else $error("program counter block 0 decode wrong");
    a_pc_blk1_map: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R14
        REQ.pc >= BLK1_START && REQ.pc < BLK2_START |-> pc_blk == 3'h1)
        else $error("program counter block 1 decode wrong");
    a_pc_blk2_map: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see R14
        REQ.pc >= BLK2_START && REQ.pc < BLK3_START |-> pc_blk == 3'h2)
        else $error("program counter block 2 decode wrong");
endmodule
`default_nettype wire

// >>> testbench/pmp_flash_model.sv
// Behavioural program flash on the far side of the guard
`timescale 1ns/1ps
`default_nettype none
module pmp_flash_model
    import pmp_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [ADDR_W-1:0] rd_ptr,
    input  wire logic              we,
    input  wire logic [ADDR_W-1:0] waddr,
    input  wire logic [DATA_W-1:0] wdata,
    output logic [DATA_W-1:0]      rdata
);
    logic [DATA_W-1:0] mem [0:65535];
    logic [ADDR_W-1:0] ptr_q;
    // Unwritten words hold an address pattern, so a stale word never looks right
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 16'(i) ^ 16'hA5A5;
        end
    end
    // Read address is the pointer of the previous cycle; only a strobed write alters a word
    // Upper address bits dropped: config words alias onto the low 64K words
    always @(posedge clk) begin
        ptr_q <= rd_ptr;
        if (we) begin
            mem[waddr[15:0]] <= wdata;
        end
    end
    assign rdata = mem[ptr_q[15:0]];
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench for the program memory protection guard
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pmp_pkg::*;
    logic              REF_CLK, RST_N, ERASE_CHIP, ERASE_BLOCK, ERASE_EXTERNAL;
    logic              RVALID, REFUSED, FLASH_WE, FLASH_ERASE, refd, wr;
    logic [2:0]        ERASE_SEL, FLASH_ERASE_SEL;
    logic [DATA_W-1:0] FLASH_RDATA, RDATA, FLASH_WDATA, PROT_WORD, rd, wdv;
    logic [ADDR_W-1:0] FLASH_ADDR, wa;
    pmp_req_type       REQ;
    int                error_cnt, n_checks, v_cyc;
    localparam logic [DATA_W-1:0] TB_ID = 16'h5A3C;  // Arbitrary identification value

    pmp_guard #(.DEVICE_ID(TB_ID)) u_pmp_guard (.REF_CLK(REF_CLK), .RST_N(RST_N), .REQ(REQ),
        .ERASE_CHIP(ERASE_CHIP), .ERASE_BLOCK(ERASE_BLOCK), .ERASE_SEL(ERASE_SEL),
        .ERASE_EXTERNAL(ERASE_EXTERNAL), .FLASH_RDATA(FLASH_RDATA), .RDATA(RDATA),
        .RVALID(RVALID), .REFUSED(REFUSED), .FLASH_WE(FLASH_WE), .FLASH_ADDR(FLASH_ADDR),
        .FLASH_WDATA(FLASH_WDATA), .FLASH_ERASE(FLASH_ERASE),
        .FLASH_ERASE_SEL(FLASH_ERASE_SEL), .PROT_WORD(PROT_WORD));
    pmp_flash_model u_pmp_flash_model (.clk(REF_CLK), .rd_ptr(REQ.table_pointer),
        .we(FLASH_WE), .waddr(FLASH_ADDR), .wdata(FLASH_WDATA), .rdata(FLASH_RDATA));

    // 50 MHz core clock
    initial begin
        REF_CLK = 1'b0;
        forever #10 REF_CLK = ~REF_CLK;
    end

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Expected content of a never-written flash word
    function automatic logic [15:0] pat(input logic [20:0] a);
        return a[15:0] ^ 16'hA5A5;
    endfunction

    // One table op; records answers seen over the three cycles after it is taken
    task automatic xfer(input pmp_op_type op, input logic [20:0] ptr, input logic [20:0] pc,
                        input logic [15:0] wd, input logic ext);
        @(posedge REF_CLK);
        REQ <= '{op, ptr, pc, wd, ext};
        @(posedge REF_CLK);
        REQ.op <= OP_NONE;
        v_cyc = 0;
        refd = 1'b0;
        wr = 1'b0;
        for (int i = 1; i < 4; i++) begin
            #1;
            if (RVALID === 1'b1) begin
                v_cyc = i;
                rd = RDATA;
            end
            if (REFUSED === 1'b1) refd = 1'b1;
            if (FLASH_WE === 1'b1) begin
                wr = 1'b1;
                wa = FLASH_ADDR;
                wdv = FLASH_WDATA;
            end
            @(posedge REF_CLK);
        end
    endtask

    // Erase strobe; checks the flash erase pulse and the protection word after it
    task automatic erase(input logic chip, input logic ext, input logic [2:0] sel,
                         input logic [2:0] esel, input logic [15:0] prot);
        @(posedge REF_CLK);
        ERASE_CHIP <= chip;
        ERASE_BLOCK <= ~chip;
        ERASE_SEL <= sel;
        ERASE_EXTERNAL <= ext;
        @(posedge REF_CLK);
        ERASE_CHIP <= 1'b0;
        ERASE_BLOCK <= 1'b0;
        #1;
        chk("erase_pulse", FLASH_ERASE, ext);
        if (ext) chk("erase_sel", FLASH_ERASE_SEL, esel);
        @(posedge REF_CLK);
        ERASE_EXTERNAL <= 1'b0;
        #1;
        chk("prot_after_erase", PROT_WORD, prot);
    endtask

    task automatic t_plain();
        xfer(OP_READ, PROT_ADDR, 21'h0, 16'h0, 1'b0);
        chk("prot_rd", {v_cyc[3:0], rd}, {4'h1, PROT_RESET});
        xfer(OP_READ, DEVID_ADDR, 21'h0, 16'h0, 1'b0);
        chk("id_rd", {v_cyc[3:0], rd}, {4'h1, TB_ID});
        xfer(OP_WRITE, 21'h300002, 21'h000100, 16'hC3C3, 1'b0);
        chk("wr_cfg", {wr, wa, wdv}, {1'b1, 21'h300002, 16'hC3C3});
        xfer(OP_READ, 21'h300002, 21'h000100, 16'h0, 1'b0);
        chk("rd_cfg", {v_cyc[3:0], rd}, {4'h2, 16'hC3C3});
        xfer(OP_WRITE, 21'h00C123, 21'h000100, 16'hBEEF, 1'b0);
        chk("wr_blk3", {wr, wa, wdv}, {1'b1, 21'h00C123, 16'hBEEF});
        xfer(OP_READ, 21'h00C123, 21'h000100, 16'h0, 1'b0);
        chk("rd_blk3", {v_cyc[3:0], rd}, {4'h2, 16'hBEEF});
        xfer(OP_READ, 21'h003FFF, 21'h004000, 16'h0, 1'b0);
        chk("rd_blk0_top", {v_cyc[3:0], rd}, {4'h2, pat(21'h003FFF)});
    endtask

    // Block 0 write-protected, block 1 table-read-protected
    task automatic t_protect();
        xfer(OP_WRITE, PROT_ADDR, 21'h0, 16'h7FBE, 1'b0);
        xfer(OP_WRITE, PROT_ADDR, 21'h0, 16'h7FFF, 1'b0);
        chk("prot_sticky", PROT_WORD, 16'h7FBE);
        xfer(OP_WRITE, 21'h000800, 21'h008FEF, 16'h1111, 1'b0);
        chk("wr_blk0_far", {refd, wr}, 2'b10);
        xfer(OP_WRITE, 21'h003FFF, 21'h003FFE, 16'h2222, 1'b0);
        chk("wr_blk0_same", {refd, wr}, 2'b10);
        xfer(OP_READ, 21'h004000, 21'h007FFE, 16'h0, 1'b0);
        chk("rd_blk1_same", {v_cyc[3:0], rd}, {4'h2, pat(21'h004000)});
        xfer(OP_READ, 21'h007FFF, 21'h008000, 16'h0, 1'b0);
        chk("rd_blk1_above", {v_cyc[3:0], rd}, {4'h2, 16'h0000});
        xfer(OP_READ, 21'h004010, 21'h003FFF, 16'h0, 1'b0);
        chk("rd_blk1_below", {v_cyc[3:0], rd}, {4'h2, 16'h0000});
    endtask

    // Code protect on block 2 only stops the external programmer
    task automatic t_code();
        xfer(OP_WRITE, PROT_ADDR, 21'h0, 16'h6FFF, 1'b0);
        xfer(OP_READ, 21'h008100, 21'h0, 16'h0, 1'b1);
        chk("ext_rd_cp", {refd, v_cyc[3:0], rd}, {1'b1, 4'h1, 16'h0000});
        xfer(OP_WRITE, 21'h008100, 21'h0, 16'h3333, 1'b1);
        chk("ext_wr_cp", {refd, wr}, 2'b10);
        xfer(OP_READ, 21'h008100, 21'h008000, 16'h0, 1'b0);
        chk("int_rd_cp", {v_cyc[3:0], rd}, {4'h2, pat(21'h008100)});
    endtask

    task automatic final_report();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the about 110 cycles the tests need
    initial begin
        repeat (4000) @(posedge REF_CLK);
        error_cnt++;
        final_report();
    end

    initial begin
        RST_N = 1'b0;
        REQ = '0;
        ERASE_CHIP = 1'b0;
        ERASE_BLOCK = 1'b0;
        ERASE_SEL = 3'h0;
        ERASE_EXTERNAL = 1'b0;
        repeat (16) @(posedge REF_CLK);
        RST_N <= 1'b1;
        #1;
        chk("prot_reset", PROT_WORD, PROT_RESET);
        t_plain();
        t_protect();
        erase(1'b0, 1'b0, 3'h1, 3'h1, 16'h7FBE);
        erase(1'b0, 1'b1, 3'h1, 3'h1, 16'h7FFE);
        erase(1'b1, 1'b1, 3'h0, 3'h7, 16'h7FFF);
        t_code();
        final_report();
    end
endmodule
`default_nettype wire
